// file: rtl/epf_defines.vh
// constants for the exception pending flag block: offsets, field positions, reset values
`ifndef EPF_DEFINES_VH
`define EPF_DEFINES_VH

// bus widths
`define EPF_ADDR_W 12
`define EPF_IDX_W 10
`define EPF_DATA_W 32
`define EPF_REG_W 8
`define EPF_FLAG_W 24
`define EPF_LANES 3
`define EPF_IDX_LSB 2

// register indices; byte address is four times the index
`define EPF_IDX_PEND_LOW 10'h010
`define EPF_IDX_PEND_MID 10'h011
`define EPF_IDX_PEND_HIGH 10'h012
`define EPF_IDX_MASK_A_LOW 10'h014
`define EPF_IDX_MASK_A_MID 10'h015
`define EPF_IDX_MASK_A_HIGH 10'h016
`define EPF_IDX_MASK_B_LOW 10'h018
`define EPF_IDX_MASK_B_MID 10'h019
`define EPF_IDX_MASK_B_HIGH 10'h01a

// reset values
`define EPF_PEND_RST 24'h000000
`define EPF_MASK_RST 24'h000000
`define EPF_READ_ZERO 32'h00000000

// byte lanes inside the 24-bit words
`define EPF_LOW_LSB 0
`define EPF_MID_LSB 8
`define EPF_HIGH_LSB 16
`define EPF_LOW_MSB 7
`define EPF_MID_MSB 15
`define EPF_HIGH_MSB 23

// flag bit positions
`define EPF_BIT_RADIO_IDLE 0
`define EPF_BIT_FRAME_SENT 1
`define EPF_BIT_ACK_SENT 2
`define EPF_BIT_TX_UNDERFLOW 3
`define EPF_BIT_TX_OVERFLOW 4
`define EPF_BIT_RX_UNDERFLOW 5
`define EPF_BIT_RX_OVERFLOW 6
`define EPF_BIT_RX_MASK_CLEARED 7
`define EPF_BIT_FRAME_RECEIVED 8
`define EPF_BIT_FRAME_ACCEPTED 9
`define EPF_BIT_LOOKUP_FINISHED 10
`define EPF_BIT_LOOKUP_HIT 11
`define EPF_BIT_RX_THRESHOLD 12
`define EPF_BIT_START_DELIMITER 13
`define EPF_BIT_SEC_LOW_DONE 14
`define EPF_BIT_SEC_HIGH_DONE 15
`define EPF_BIT_MEM_ADDR_FAULT 16
`define EPF_BIT_USAGE_FAULT 17
`define EPF_BIT_OPERAND_FAULT 18
`define EPF_BIT_SERIAL_FAULT 19
`define EPF_BIT_SYNTH_UNLOCKED 20
`define EPF_BIT_FRAME_ABORTED 21
`define EPF_BIT_MOVE_TIMEOUT 22
`define EPF_BIT_UNUSED 23

// bits that have a source; bit 23 never sets
`define EPF_FLAG_USED 24'h7fffff

`endif

// file: rtl/epf_flag_bank.v
// pending flag storage: hardware sets, software write-zero clears per byte lane
`timescale 1ns/1ps
`default_nettype none
`include "epf_defines.vh"
module epf_flag_bank (
  input wire pclk,
  input wire presetn,
  input wire [`EPF_FLAG_W-1:0] set_vec,
  input wire [`EPF_LANES-1:0] clr_lane,
  input wire [`EPF_REG_W-1:0] clr_data,
  output reg [`EPF_FLAG_W-1:0] flags
);

wire [`EPF_FLAG_W-1:0] lane_mask;
wire [`EPF_FLAG_W-1:0] clear_vec;
wire [`EPF_FLAG_W-1:0] next_flags;

// only the written lane is touched; ones in the data keep the bit as it is
assign lane_mask = {{`EPF_REG_W{clr_lane[2]}}, {`EPF_REG_W{clr_lane[1]}}, {`EPF_REG_W{clr_lane[0]}}};
assign clear_vec = lane_mask & ~{clr_data, clr_data, clr_data};

// set is ored in after the clear, so a coincident event survives
assign next_flags = ((flags & ~clear_vec) | set_vec) & `EPF_FLAG_USED;

// flags hold until a zero write or reset clears them; no event path clears them
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    flags <= `EPF_PEND_RST;
  end
  else
  begin
    flags <= next_flags;
  end
end

endmodule
`default_nettype wire

// file: rtl/epf_apb_slave.v
// apb slave front end: decode, zero-wait handshake, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "epf_defines.vh"
module epf_apb_slave (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`EPF_ADDR_W-1:0] paddr,
  input wire [`EPF_REG_W-1:0] rd_byte,
  output wire [`EPF_IDX_W-1:0] reg_idx,
  output wire wr_strobe,
  output reg [`EPF_DATA_W-1:0] prdata,
  output wire pready,
  output wire pslverr
);

// true for every index that holds a register
function is_mapped;
  input [`EPF_IDX_W-1:0] idx;
  begin
    case (idx)
      `EPF_IDX_PEND_LOW, `EPF_IDX_PEND_MID, `EPF_IDX_PEND_HIGH,
      `EPF_IDX_MASK_A_LOW, `EPF_IDX_MASK_A_MID, `EPF_IDX_MASK_A_HIGH,
      `EPF_IDX_MASK_B_LOW, `EPF_IDX_MASK_B_MID, `EPF_IDX_MASK_B_HIGH:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  end
endfunction

wire aligned;
wire hit;
wire setup_rd;

// misaligned addresses count as unmapped
assign aligned = (paddr[`EPF_IDX_LSB-1:0] == 2'b00);
assign reg_idx = paddr[`EPF_ADDR_W-1:`EPF_IDX_LSB];
assign hit = aligned & is_mapped(reg_idx);

// read data is captured in setup so the access phase needs no wait state
assign setup_rd = psel & ~penable & ~pwrite;
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;
assign wr_strobe = psel & penable & pwrite & hit;

// unmapped reads answer zero; upper bytes always read zero
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    prdata <= `EPF_READ_ZERO;
  end
  else if (setup_rd)
  begin
    prdata <= hit ? {{(`EPF_DATA_W-`EPF_REG_W){1'b0}}, rd_byte} : `EPF_READ_ZERO;
  end
end

endmodule
`default_nettype wire

// file: rtl/epf_top.v
// exception pending flags with channel masks behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "epf_defines.vh"
module epf_top (
  input wire pclk,
  input wire presetn,
  // apb slave port
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`EPF_ADDR_W-1:0] paddr,
  input wire [`EPF_DATA_W-1:0] pwdata,
  output wire [`EPF_DATA_W-1:0] prdata,
  output wire pready,
  output wire pslverr,
  // low byte event sources
  input wire radio_idle_event,
  input wire frame_sent_event,
  input wire ack_sent_event,
  input wire tx_underflow_event,
  input wire tx_overflow_event,
  input wire rx_underflow_event,
  input wire rx_overflow_event,
  input wire receive_mask_cleared_event,
  // middle byte event sources
  input wire frame_received_event,
  input wire frame_accepted_event,
  input wire source_lookup_finished,
  input wire source_lookup_hit,
  input wire receive_threshold_event,
  input wire start_delimiter_event,
  input wire security_unit_low_done,
  input wire security_unit_high_done,
  // high byte event sources
  input wire memory_address_fault,
  input wire command_usage_fault,
  input wire command_operand_fault,
  input wire serial_port_fault,
  input wire synthesizer_unlocked_event,
  input wire frame_reception_aborted,
  input wire buffer_move_timeout,
  // state toward the pin logic
  output wire [`EPF_FLAG_W-1:0] exception_pending_bits,
  output reg channel_a_indication,
  output reg channel_a_comp_indication,
  output reg channel_b_indication,
  output reg channel_b_comp_indication
);

// true when any flag falls inside the given mask
function any_hit;
  input [`EPF_FLAG_W-1:0] pend;
  input [`EPF_FLAG_W-1:0] sel;
  begin
    any_hit = |(pend & sel & `EPF_FLAG_USED);
  end
endfunction

wire [`EPF_IDX_W-1:0] reg_idx;
wire wr_strobe;
wire [`EPF_REG_W-1:0] wr_byte;
wire [`EPF_FLAG_W-1:0] set_vec;
wire [`EPF_FLAG_W-1:0] flags;
wire [`EPF_LANES-1:0] clr_lane;
reg [`EPF_REG_W-1:0] rd_byte;
reg [`EPF_FLAG_W-1:0] channel_a_select_mask;
reg [`EPF_FLAG_W-1:0] channel_b_select_mask;
wire next_chan_a;
wire next_chan_a_comp;
wire next_chan_b;
wire next_chan_b_comp;

// registers are eight bits wide and sit in the low lane of the word
assign wr_byte = pwdata[`EPF_REG_W-1:0];

// bus front end
epf_apb_slave u_bus (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .rd_byte(rd_byte),
  .reg_idx(reg_idx),
  .wr_strobe(wr_strobe),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);

// low byte: radio and buffer events
assign set_vec[`EPF_BIT_RADIO_IDLE] = radio_idle_event;
assign set_vec[`EPF_BIT_FRAME_SENT] = frame_sent_event;
assign set_vec[`EPF_BIT_ACK_SENT] = ack_sent_event;
assign set_vec[`EPF_BIT_TX_UNDERFLOW] = tx_underflow_event;
assign set_vec[`EPF_BIT_TX_OVERFLOW] = tx_overflow_event;
assign set_vec[`EPF_BIT_RX_UNDERFLOW] = rx_underflow_event;
assign set_vec[`EPF_BIT_RX_OVERFLOW] = rx_overflow_event;
assign set_vec[`EPF_BIT_RX_MASK_CLEARED] = receive_mask_cleared_event;

// middle byte: reception, filtering and security events
assign set_vec[`EPF_BIT_FRAME_RECEIVED] = frame_received_event;
assign set_vec[`EPF_BIT_FRAME_ACCEPTED] = frame_accepted_event;
assign set_vec[`EPF_BIT_LOOKUP_FINISHED] = source_lookup_finished;
assign set_vec[`EPF_BIT_LOOKUP_HIT] = source_lookup_hit;
assign set_vec[`EPF_BIT_RX_THRESHOLD] = receive_threshold_event;
assign set_vec[`EPF_BIT_START_DELIMITER] = start_delimiter_event;
assign set_vec[`EPF_BIT_SEC_LOW_DONE] = security_unit_low_done;
assign set_vec[`EPF_BIT_SEC_HIGH_DONE] = security_unit_high_done;

// high byte: host access faults, synthesizer unlock, reception abort and move timeout; top bit has no source
assign set_vec[`EPF_BIT_MEM_ADDR_FAULT] = memory_address_fault;
assign set_vec[`EPF_BIT_USAGE_FAULT] = command_usage_fault;
assign set_vec[`EPF_BIT_OPERAND_FAULT] = command_operand_fault;
assign set_vec[`EPF_BIT_SERIAL_FAULT] = serial_port_fault;
assign set_vec[`EPF_BIT_SYNTH_UNLOCKED] = synthesizer_unlocked_event;
assign set_vec[`EPF_BIT_FRAME_ABORTED] = frame_reception_aborted;
assign set_vec[`EPF_BIT_MOVE_TIMEOUT] = buffer_move_timeout;
assign set_vec[`EPF_BIT_UNUSED] = 1'b0;

// one lane per flag byte at consecutive indices
assign clr_lane[0] = wr_strobe & (reg_idx == `EPF_IDX_PEND_LOW);
assign clr_lane[1] = wr_strobe & (reg_idx == `EPF_IDX_PEND_MID);
assign clr_lane[2] = wr_strobe & (reg_idx == `EPF_IDX_PEND_HIGH);

// flag storage
epf_flag_bank u_flags (
  .pclk(pclk),
  .presetn(presetn),
  .set_vec(set_vec),
  .clr_lane(clr_lane),
  .clr_data(wr_byte),
  .flags(flags)
);

assign exception_pending_bits = flags;

// channel masks are plain read/write bytes
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    channel_a_select_mask <= `EPF_MASK_RST;
    channel_b_select_mask <= `EPF_MASK_RST;
  end
  else if (wr_strobe)
  begin
    case (reg_idx)
      `EPF_IDX_MASK_A_LOW:
        channel_a_select_mask[`EPF_LOW_MSB:`EPF_LOW_LSB] <= wr_byte;
      `EPF_IDX_MASK_A_MID:
        channel_a_select_mask[`EPF_MID_MSB:`EPF_MID_LSB] <= wr_byte;
      `EPF_IDX_MASK_A_HIGH:
        channel_a_select_mask[`EPF_HIGH_MSB:`EPF_HIGH_LSB] <= wr_byte;
      `EPF_IDX_MASK_B_LOW:
        channel_b_select_mask[`EPF_LOW_MSB:`EPF_LOW_LSB] <= wr_byte;
      `EPF_IDX_MASK_B_MID:
        channel_b_select_mask[`EPF_MID_MSB:`EPF_MID_LSB] <= wr_byte;
      `EPF_IDX_MASK_B_HIGH:
        channel_b_select_mask[`EPF_HIGH_MSB:`EPF_HIGH_LSB] <= wr_byte;
      default:
        channel_a_select_mask <= channel_a_select_mask;
    endcase
  end
end

// read mux: flags read back exactly as stored, so one means pending
always @*
begin
  rd_byte = {`EPF_REG_W{1'b0}};
  case (reg_idx)
    `EPF_IDX_PEND_LOW:
      rd_byte = flags[`EPF_LOW_MSB:`EPF_LOW_LSB];
    `EPF_IDX_PEND_MID:
      rd_byte = flags[`EPF_MID_MSB:`EPF_MID_LSB];
    `EPF_IDX_PEND_HIGH:
      rd_byte = flags[`EPF_HIGH_MSB:`EPF_HIGH_LSB];
    `EPF_IDX_MASK_A_LOW:
      rd_byte = channel_a_select_mask[`EPF_LOW_MSB:`EPF_LOW_LSB];
    `EPF_IDX_MASK_A_MID:
      rd_byte = channel_a_select_mask[`EPF_MID_MSB:`EPF_MID_LSB];
    `EPF_IDX_MASK_A_HIGH:
      rd_byte = channel_a_select_mask[`EPF_HIGH_MSB:`EPF_HIGH_LSB];
    `EPF_IDX_MASK_B_LOW:
      rd_byte = channel_b_select_mask[`EPF_LOW_MSB:`EPF_LOW_LSB];
    `EPF_IDX_MASK_B_MID:
      rd_byte = channel_b_select_mask[`EPF_MID_MSB:`EPF_MID_LSB];
    `EPF_IDX_MASK_B_HIGH:
      rd_byte = channel_b_select_mask[`EPF_HIGH_MSB:`EPF_HIGH_LSB];
    default:
      rd_byte = {`EPF_REG_W{1'b0}};
  endcase
end

// selected pending flags drive the channel; masked ones drive its complement
assign next_chan_a = any_hit(flags, channel_a_select_mask);
assign next_chan_a_comp = any_hit(flags, ~channel_a_select_mask);
assign next_chan_b = any_hit(flags, channel_b_select_mask);
assign next_chan_b_comp = any_hit(flags, ~channel_b_select_mask);

// registered to keep the pin path glitch free; costs one cycle of latency
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    channel_a_indication <= 1'b0;
    channel_a_comp_indication <= 1'b0;
    channel_b_indication <= 1'b0;
    channel_b_comp_indication <= 1'b0;
  end
  else
  begin
    channel_a_indication <= next_chan_a;
    channel_a_comp_indication <= next_chan_a_comp;
    channel_b_indication <= next_chan_b;
    channel_b_comp_indication <= next_chan_b_comp;
  end
end

endmodule
`default_nettype wire

// file: testbench/epf_monitor.sv
// concurrent checks on the exception pending flag block ports
`timescale 1ns/1ps
`default_nettype none
`include "epf_defines.vh"
module epf_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`EPF_ADDR_W-1:0] paddr,
  input wire logic [`EPF_DATA_W-1:0] pwdata,
  input wire logic [`EPF_DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic [`EPF_FLAG_W-1:0] exception_pending_bits,
  input wire logic radio_idle_event,
  input wire logic buffer_move_timeout
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // zero wait states, so every access phase is also the completing edge
  wire logic wr_low = psel && penable && pwrite && (paddr == 12'h040);
  sequence s_read_setup(a);
    psel && !penable && !pwrite && (paddr == a);
  endsequence
  sequence s_clear_low(b);
    wr_low && !pwdata[b];
  endsequence
  chk_event_sets_flag: assert property (radio_idle_event |=> exception_pending_bits[0])
    else $error("event did not set its flag");
  chk_flag_stays_set: assert property (exception_pending_bits[0] && !(wr_low && !pwdata[0])
    |=> exception_pending_bits[0])
    else $error("flag dropped without a zero write");
  chk_zero_write_clears: assert property (s_clear_low(0) ##0 !radio_idle_event
    |=> !exception_pending_bits[0])
    else $error("zero write left flag set");
  chk_set_beats_clear: assert property (s_clear_low(0) ##0 radio_idle_event
    |=> exception_pending_bits[0])
    else $error("clear won over same-cycle set");
  chk_no_soft_set: assert property (!exception_pending_bits[0] && !radio_idle_event
    |=> !exception_pending_bits[0])
    else $error("flag set without its event");
  chk_high_lane_set: assert property (buffer_move_timeout |=> exception_pending_bits[22])
    else $error("move timeout flag not set");
  chk_unused_bit: assert property (exception_pending_bits[23] == 1'b0)
    else $error("bit 23 became set");
  chk_read_low_byte: assert property (s_read_setup(12'h040)
    |=> prdata == {24'h000000, $past(exception_pending_bits[7:0])})
    else $error("low byte read data wrong");
  chk_hole_error: assert property (psel && penable && paddr == 12'h04c |-> pslverr)
    else $error("unmapped access not flagged");
endmodule
bind epf_top epf_monitor epf_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .exception_pending_bits(exception_pending_bits), .radio_idle_event(radio_idle_event),
  .buffer_move_timeout(buffer_move_timeout));
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the exception pending flag block over apb
`timescale 1ns/1ps
`default_nettype none
`include "epf_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [`EPF_ADDR_W-1:0] paddr = '0;
  logic [`EPF_DATA_W-1:0] pwdata = '0;
  logic [`EPF_DATA_W-1:0] rd;
  logic perr;
  logic [22:0] ev = '0;
  wire logic [`EPF_DATA_W-1:0] prdata;
  wire logic pready, pslverr, ind_a, cmp_a, ind_b, cmp_b;
  wire logic [`EPF_FLAG_W-1:0] flags;
  int err_total = 0;
  int num_checks = 0;
  // flag bytes first, then mask a and mask b, each low to high
  logic [9:0] idx_tab [9] = '{`EPF_IDX_PEND_LOW, `EPF_IDX_PEND_MID, `EPF_IDX_PEND_HIGH, `EPF_IDX_MASK_A_LOW,
    `EPF_IDX_MASK_A_MID, `EPF_IDX_MASK_A_HIGH, `EPF_IDX_MASK_B_LOW, `EPF_IDX_MASK_B_MID, `EPF_IDX_MASK_B_HIGH};
  epf_top epf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .radio_idle_event(ev[0]), .frame_sent_event(ev[1]), .ack_sent_event(ev[2]), .tx_underflow_event(ev[3]),
    .tx_overflow_event(ev[4]), .rx_underflow_event(ev[5]), .rx_overflow_event(ev[6]),
    .receive_mask_cleared_event(ev[7]), .frame_received_event(ev[8]), .frame_accepted_event(ev[9]),
    .source_lookup_finished(ev[10]), .source_lookup_hit(ev[11]), .receive_threshold_event(ev[12]),
    .start_delimiter_event(ev[13]), .security_unit_low_done(ev[14]), .security_unit_high_done(ev[15]),
    .memory_address_fault(ev[16]), .command_usage_fault(ev[17]), .command_operand_fault(ev[18]),
    .serial_port_fault(ev[19]), .synthesizer_unlocked_event(ev[20]), .frame_reception_aborted(ev[21]),
    .buffer_move_timeout(ev[22]), .exception_pending_bits(flags), .channel_a_indication(ind_a),
    .channel_a_comp_indication(cmp_a), .channel_b_indication(ind_b), .channel_b_comp_indication(cmp_b));
  // 50 mhz clock
  initial
  forever #10 pclk = ~pclk;
  // one apb transfer; e raises events during the access phase to collide with a write
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [22:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ev <= e;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) `CHK(pready, 1'b1)
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= '0;
  endtask
  // one-cycle event pulse, then wait until the flag update has landed
  task automatic pulse(input logic [22:0] e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= '0;
    @(negedge pclk);
  endtask
  // every flag, mask and indication is zero straight after a reset
  task automatic check_cleared;
    `CHK({flags, ind_a, cmp_a, ind_b, cmp_b}, 28'h0)
    for (int i = 0; i < 9; i++)
    begin
      apb(0, {idx_tab[i], 2'b00}, 0, 0);
      `CHK(rd, 32'h0)
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // the whole sequence takes well under 2000 cycles
  initial
  begin
    #100000;
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check_cleared();
    apb(0, 12'h04c, 0, 0);
    `CHK({perr, rd}, {1'b1, 32'h0})
    $display("test reset done");
    // each source sets only its own bit, in its own byte
    for (int i = 0; i < 23; i++)
    begin
      pulse(23'h1 << i);
      `CHK(flags, 24'h1 << i)
      apb(0, {idx_tab[i/8], 2'b00}, 0, 0);
      `CHK(rd, 32'h1 << (i % 8))
      apb(1, {idx_tab[i/8], 2'b00}, 0, 0);
      @(negedge pclk);
      `CHK(flags, 24'h0)
    end
    $display("test mapping done");
    pulse(23'h7fffff);
    for (int i = 0; i < 3; i++)
      apb(1, {idx_tab[i], 2'b00}, 32'hff, 0);
    @(negedge pclk);
    `CHK(flags, 24'h7fffff)
    apb(1, {idx_tab[0], 2'b00}, 32'h0f, 0);
    apb(1, {idx_tab[1], 2'b00}, 32'h5a, 0);
    apb(1, {idx_tab[2], 2'b00}, 32'h80, 0);
    @(negedge pclk);
    `CHK(flags, 24'h005a0f)
    apb(0, {idx_tab[1], 2'b00}, 0, 0);
    `CHK(rd, 32'h5a)
    apb(1, {idx_tab[0], 2'b00}, 0, 23'h1);
    @(negedge pclk);
    `CHK(flags, 24'h005a01)
    apb(1, {idx_tab[1], 2'b00}, 0, 0);
    $display("test clearing done");
    // only flag 0 pending; mask a selects it, mask b masks everything
    apb(1, {idx_tab[3], 2'b00}, 32'h01, 0);
    repeat (2) @(negedge pclk);
    `CHK({ind_a, cmp_a, ind_b, cmp_b}, 4'b1001)
    apb(0, {idx_tab[3], 2'b00}, 0, 0);
    `CHK(rd, 32'h01)
    apb(1, {idx_tab[0], 2'b00}, 0, 0);
    repeat (2) @(negedge pclk);
    `CHK({ind_a, cmp_a, ind_b, cmp_b}, 4'b0000)
    pulse(23'h400000);
    repeat (2) @(negedge pclk);
    `CHK({ind_a, cmp_a, ind_b, cmp_b}, 4'b0101)
    // mask b now selects the pending move timeout, so its plain output rises
    apb(1, {idx_tab[8], 2'b00}, 32'h40, 0);
    repeat (2) @(negedge pclk);
    `CHK({ind_a, cmp_a, ind_b, cmp_b}, 4'b0110)
    // every mask byte keeps its own value
    for (int i = 3; i < 9; i++)
      apb(1, {idx_tab[i], 2'b00}, 32'h11 * i, 0);
    for (int i = 3; i < 9; i++)
    begin
      apb(0, {idx_tab[i], 2'b00}, 0, 0);
      `CHK(rd, 32'h11 * i)
    end
    $display("test masks done");
    // a reset in mid-run drops pending flags, masks and indications
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check_cleared();
    $display("test mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
